// ==== include/psp_pkg.sv ====
// package: register map, field positions, reset values and timing figures of the scanner port
package psp_pkg;
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_DATA = 6'h00;
	localparam logic [5:0] IDX_STATUS = 6'h01;
	localparam logic [5:0] IDX_CONTROL = 6'h02;
	localparam logic [5:0] IDX_CONFIG = 6'h03;
	localparam logic [5:0] IDX_EVT = 6'h04;
	localparam logic [5:0] IDX_MASK = 6'h05;
	// status fields
	localparam int ST_BUSY = 7;
	localparam int ST_ACK = 6;
	localparam int ST_FAULT = 5;
	localparam int ST_SEL = 4;
	localparam int ST_PERR = 3;
	localparam int ST_SCLK = 0;
	// control fields
	localparam int CT_HBUSY = 7;
	localparam int CT_IRQEN = 4;
	localparam int CT_BUFEN = 3;
	localparam int CT_INIT = 2;
	localparam int CT_DIR = 1;
	localparam int CT_STRB = 0;
	localparam logic [7:0] CT_SCAN_MASK = 8'h9f;
	localparam logic [7:0] CT_PRN_MASK = 8'h1f;
	// configuration fields
	localparam int CF_SCAN = 6;
	localparam int CF_IRQ_LO = 0;
	localparam int CF_IRQ_W = 2;
	localparam logic [7:0] CF_MASK = 8'h43;
	// event fields
	localparam int EV_ACK = 0;
	localparam int EV_SCLK = 1;
	localparam int EV_W = 2;
	// reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [EV_W-1:0] MASK_RST = 2'h0;
	// software-timed figures, not enforced by hardware
	localparam int CLK_MHZ = 250;
	localparam real RESET_LOW_US = 100.0;
	localparam real STROBE_HIGH_US = 1.8;
	localparam real DATA_SETUP_US = 0.3;
	localparam int RESET_LOW_CYC = $rtoi($ceil(RESET_LOW_US * CLK_MHZ));
	localparam int STROBE_HIGH_CYC = $rtoi($ceil(STROBE_HIGH_US * CLK_MHZ));
	localparam int DATA_SETUP_CYC = $rtoi($ceil(DATA_SETUP_US * CLK_MHZ));
	typedef enum logic [1:0] {
		PSP_IDLE = 2'b00,
		PSP_ACK = 2'b01
	} psp_bus_t;
endpackage

// ==== rtl/psp_port.sv ====
// parallel scanner port: wishbone register file, pin drive and acknowledge interrupt
`timescale 1ns/10ps
// Summary of operation
// - configuration bit 6 selects scanner behaviour instead of printer behaviour
// - scanner mode: data writes drive the data pins while control bit 1 is 1, reads return received byte
// - status bit 7 reads 0 while scanner in print mode is busy
// - status bit 6 is 0 when scanner can take another character
// - status bit 5 follows the fault pin; 0 means scanner error
// - scanner mode: status bit 4 is 1 when scanner selected; bits 3 to 1 reserved
// - scanner mode: status bit 0 returns scanner clock input pin level without inversion
// - scanner mode: error pin becomes output driven by control bit 7, reset 0
// - control bit 4 enables interrupt on acknowledge deassertion; bits 6-5 reserved
// - control bit 3 drives the buffer enable pin; 1 disables transceiver
// - control bit 1 drives direction pin; 1 host to scanner
// - control bit 2 drives scanner reset; 0 resets; software holds 100 us
// - control bit 0 drives strobe; software holds 1.8 us after 0.3 us setup
// - port serves printer or scanner interface, never both at once
// - acknowledge interrupt goes out on the configured request line
module psp_port #(
	parameter int IRQ_LINES = 4
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] parallel_data_pins_i,
	output logic [7:0] parallel_data_pins_o,
	output logic parallel_data_pins_oe,
	input wire logic busy_pin_i,
	input wire logic ack_pin_i,
	input wire logic fault_pin_i,
	input wire logic select_pin_i,
	input wire logic scanner_clock_input_pin_i,
	input wire logic error_pin_i,
	output logic error_pin_o,
	output logic error_pin_oe,
	output logic data_clock_pulse_o,
	output logic init_pin_o,
	output logic buffer_enable_pin_o,
	output logic direction_pin_o,
	output logic [IRQ_LINES-1:0] irq_o
);
	import psp_pkg::*;

	initial begin
		if (IRQ_LINES < 1 || IRQ_LINES > (1 << CF_IRQ_W)) begin
			$error("psp_port: IRQ_LINES out of range");
		end
	end

	psp_bus_t bus_q;
	logic [7:0] data_q;
	logic [7:0] control_q;
	logic [7:0] config_q;
	logic [EV_W-1:0] evt_q;
	logic [EV_W-1:0] mask_q;
	logic ack_prev_q;
	logic sclk_prev_q;
	logic [31:0] rdat_q;
	logic scan_mode;
	logic req;
	logic wr_go;
	logic [5:0] idx;
	logic adr_ok;
	logic lane0;
	logic [7:0] status;
	logic [7:0] rd_byte;
	logic [EV_W-1:0] evt_set;
	logic [EV_W-1:0] evt_clr;
	logic irq_any;
	logic [CF_IRQ_W-1:0] irq_sel;

	assign scan_mode = config_q[CF_SCAN];
	assign req = wb_cyc_i & wb_stb_i;
	assign idx = wb_adr_i[7:2];
	assign adr_ok = (wb_adr_i[1:0] == 2'h0);
	assign lane0 = wb_sel_i[0];
	// the write lands on the edge that samples ack high
	assign wr_go = req & wb_we_i & (bus_q == PSP_ACK) & adr_ok & lane0;

	// bus handshake: one wait cycle, ack for one cycle, then dropped
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_q <= PSP_IDLE;
		end else begin
			case (bus_q)
				PSP_IDLE: begin
					if (req) begin
						bus_q <= PSP_ACK;
					end
				end
				PSP_ACK: begin
					bus_q <= PSP_IDLE;
				end
				default: begin
					bus_q <= PSP_IDLE;
				end
			endcase
		end
	end

	assign wb_ack_o = (bus_q == PSP_ACK);

	// status byte; printer mode puts the scanner clock pin on bit 4 and the inverted error pin on bit 3
	always_comb begin
		status = 8'h00;
		if (scan_mode) begin
			status[ST_BUSY] = busy_pin_i;
			status[ST_ACK] = ack_pin_i;
			status[ST_FAULT] = fault_pin_i;
			status[ST_SEL] = select_pin_i;
			status[ST_SCLK] = scanner_clock_input_pin_i;
		end else begin
			status[ST_BUSY] = busy_pin_i;
			status[ST_ACK] = ack_pin_i;
			status[ST_FAULT] = fault_pin_i;
			status[ST_SEL] = scanner_clock_input_pin_i;
			status[ST_PERR] = ~error_pin_i;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (adr_ok) begin
			case (idx)
				IDX_DATA: begin
					// scanner mode returns pin data, printer mode the last write
					rd_byte = scan_mode ? parallel_data_pins_i : data_q;
				end
				IDX_STATUS: begin
					rd_byte = status;
				end
				IDX_CONTROL: begin
					rd_byte = control_q;
				end
				IDX_CONFIG: begin
					rd_byte = config_q;
				end
				IDX_EVT: begin
					rd_byte = {{(8-EV_W){1'b0}}, evt_q};
				end
				IDX_MASK: begin
					rd_byte = {{(8-EV_W){1'b0}}, mask_q};
				end
				default: begin
					rd_byte = 8'h00;
				end
			endcase
		end
	end

	// read data captured in the request cycle, presented with ack
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdat_q <= 32'h0;
		end else if (req && bus_q == PSP_IDLE && !wb_we_i) begin
			rdat_q <= {24'h0, rd_byte};
		end
	end

	assign wb_dat_o = rdat_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			data_q <= DATA_RST;
		end else if (wr_go && idx == IDX_DATA) begin
			data_q <= wb_dat_i[7:0];
		end
	end

	// reserved control bits stay 0; bit 7 exists only in scanner mode
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			control_q <= CONTROL_RST;
		end else if (wr_go && idx == IDX_CONTROL) begin
			control_q <= wb_dat_i[7:0] & (scan_mode ? CT_SCAN_MASK : CT_PRN_MASK);
		end else if (!scan_mode) begin
			control_q[CT_HBUSY] <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			config_q <= CONFIG_RST;
		end else if (wr_go && idx == IDX_CONFIG) begin
			config_q <= wb_dat_i[7:0] & CF_MASK;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_q <= MASK_RST;
		end else if (wr_go && idx == IDX_MASK) begin
			mask_q <= wb_dat_i[EV_W-1:0];
		end
	end

	// edge history for the event detectors
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			ack_prev_q <= ack_pin_i;
			sclk_prev_q <= scanner_clock_input_pin_i;
		end
	end

	// acknowledge deassertion is a high-to-low step of the ack level
	assign evt_set[EV_ACK] = control_q[CT_IRQEN] & ack_prev_q & ~ack_pin_i;
	assign evt_set[EV_SCLK] = scan_mode & ~sclk_prev_q & scanner_clock_input_pin_i;
	assign evt_clr = (wr_go && idx == IDX_EVT) ? wb_dat_i[EV_W-1:0] : '0;

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_q <= '0;
		end else begin
			evt_q <= (evt_q & ~evt_clr) | evt_set;
		end
	end

	assign irq_any = |(evt_q & mask_q);
	assign irq_sel = config_q[CF_IRQ_LO +: CF_IRQ_W];

	// one level on the configured request line, others held low
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_LINES; gi++) begin : g_irq
			assign irq_o[gi] = irq_any & (irq_sel == CF_IRQ_W'(gi));
		end
	endgenerate

	// pins follow the control bits as levels; pulse widths are left to software timing
	assign data_clock_pulse_o = control_q[CT_STRB];
	// scanner reset is active low on the bit; printer init is the inverted bit
	assign init_pin_o = scan_mode ? control_q[CT_INIT] : ~control_q[CT_INIT];
	assign buffer_enable_pin_o = control_q[CT_BUFEN];
	assign direction_pin_o = control_q[CT_DIR];
	assign parallel_data_pins_o = data_q;
	// printer mode always drives data; scanner mode only toward the scanner
	assign parallel_data_pins_oe = scan_mode ? control_q[CT_DIR] : 1'b1;
	assign error_pin_o = control_q[CT_HBUSY];
	assign error_pin_oe = scan_mode;
endmodule

// ==== verification/psp_port_sva.sv ====
// checker: bus handshake, control pins and interrupt line of the scanner port
`timescale 1ns/10ps
module psp_port_sva #(
	parameter int IRQ_LINES = 4
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic parallel_data_pins_oe,
	input wire logic error_pin_o,
	input wire logic error_pin_oe,
	input wire logic data_clock_pulse_o,
	input wire logic buffer_enable_pin_o,
	input wire logic direction_pin_o,
	input wire logic [IRQ_LINES-1:0] irq_o
);
	logic req, wr, ctl_wr, scan_q;
	logic [7:0] wd_q;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	assign ctl_wr = wr && wb_adr_i == 8'h08;
	// mirror of mode and last control byte, so pin checks need no view inside
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			scan_q <= 1'b0;
			wd_q <= 8'h00;
		end else begin
			if (wr && wb_adr_i == 8'h0c) scan_q <= wb_dat_i[6];
			if (ctl_wr) wd_q <= wb_dat_i[7:0];
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_answer: assert property (req |=> wb_ack_o) else $error("request not answered");
	a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
	a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_ctl_pins: assert property (ctl_wr |-> ##2
		{buffer_enable_pin_o, direction_pin_o, data_clock_pulse_o} == {wd_q[3], wd_q[1:0]})
		else $error("control pins wrong");
	a_hbusy_pin: assert property (ctl_wr |-> ##2 error_pin_o == (wd_q[7] && scan_q))
		else $error("host busy pin wrong");
	a_pins_static: assert property ($changed({buffer_enable_pin_o, direction_pin_o,
		data_clock_pulse_o}) |-> $past(ctl_wr) || $past(ctl_wr, 2)) else $error("pin moved");
	// one cycle of slack after a mode or control change; the pin enables follow the registers with no extra stage
	a_oe_mode: assert property (scan_q == $past(scan_q) && !$past(ctl_wr) |->
		parallel_data_pins_oe == (!scan_q || direction_pin_o) && error_pin_oe == scan_q)
		else $error("pin enable wrong for mode");
	a_irq_line: assert property ($onehot0(irq_o)) else $error("more than one irq line");
	c_ctl_write: cover property (ctl_wr);
	c_irq: cover property (|irq_o);
	c_scan_req: cover property (scan_q && req);
endmodule
bind psp_port psp_port_sva #(.IRQ_LINES(IRQ_LINES)) u_sva (.*);

// ==== verification/psp_port_tb_top.sv ====
// testbench: register access, pin drive, status sampling and interrupts of the scanner port
`timescale 1ns/10ps
module psp_port_tb_top;
	import psp_pkg::*;
	logic mclk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic busy_pin_i = 1'b0, ack_pin_i = 1'b0, fault_pin_i = 1'b0, select_pin_i = 1'b0;
	logic scanner_clock_input_pin_i = 1'b0, wb_ack_o, parallel_data_pins_oe, error_pin_i;
	logic error_pin_o, error_pin_oe, data_clock_pulse_o, init_pin_o, buffer_enable_pin_o;
	logic direction_pin_o;
	logic [7:0] wb_adr_i = 8'h00, parallel_data_pins_i, parallel_data_pins_o, scan_pins, rx, q;
	logic [7:0] sdat = 8'h3c;
	logic [3:0] wb_sel_i = 4'h1, irq_o;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	int bad_count = 0, n_checks = 0;
	psp_port #(.IRQ_LINES(4)) uut (.*);
	psp_scanner_model far (.mclk(mclk), .dir_i(direction_pin_o), .bufen_i(buffer_enable_pin_o),
		.strobe_i(data_clock_pulse_o), .host_data_i(parallel_data_pins_i),
		.scan_data_i(sdat), .pins_o(scan_pins), .rx_q(rx));
	assign parallel_data_pins_i = parallel_data_pins_oe ? parallel_data_pins_o : scan_pins;
	// undriven line in printer mode idles at its pull-up level
	assign error_pin_i = error_pin_oe ? error_pin_o : 1'b1;
	always #2 mclk = ~mclk;
	task automatic report_and_stop;
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
		int n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			report_and_stop();
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic pulse_ack;
		ack_pin_i <= 1'b1;
		repeat (2) @(posedge mclk);
		ack_pin_i <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		chk({4'h0, init_pin_o, parallel_data_pins_oe, error_pin_oe, data_clock_pulse_o}, 8'h0c);
		wb(8'h08, 1'b0, 8'h00);
		chk(q, 8'h00);
		wb(8'h0c, 1'b1, 8'h40);
		wb(8'h0c, 1'b0, 8'h00);
		chk(q, 8'h40);
		chk({6'h00, init_pin_o, error_pin_oe}, 8'h01);
		repeat (RESET_LOW_CYC) @(posedge mclk);
		wb(8'h00, 1'b1, 8'ha5);
		wb(8'h08, 1'b1, 8'h0c);
		wb(8'h08, 1'b1, 8'h0e);
		wb(8'h08, 1'b1, 8'h06);
		repeat (DATA_SETUP_CYC) @(posedge mclk);
		chk(parallel_data_pins_i, 8'ha5);
		wb(8'h08, 1'b1, 8'hff);
		wb(8'h08, 1'b0, 8'h00);
		chk(q, 8'h9f);
		chk({error_pin_o, buffer_enable_pin_o, init_pin_o, direction_pin_o, data_clock_pulse_o,
			error_pin_oe, 2'b00}, 8'hfc);
		repeat (STROBE_HIGH_CYC) @(posedge mclk);
		chk(rx, 8'ha5);
		wb(8'h08, 1'b1, 8'h8e);
		wb(8'h08, 1'b1, 8'h0c);
		wb(8'h08, 1'b1, 8'h04);
		wb(8'h00, 1'b0, 8'h00);
		chk(q, 8'h3c);
		chk({7'h00, parallel_data_pins_oe}, 8'h00);
		for (int i = 0; i < 32; i++) begin
			{busy_pin_i, ack_pin_i, fault_pin_i, select_pin_i, scanner_clock_input_pin_i} <= i[4:0];
			wb(8'h04, 1'b0, 8'h00);
			chk(q, {i[4:1], 3'b000, i[0]});
		end
		{busy_pin_i, ack_pin_i, fault_pin_i, select_pin_i, scanner_clock_input_pin_i} <= 5'h00;
		wb(8'h10, 1'b0, 8'h00);
		chk(q, 8'h02);
		wb(8'h10, 1'b1, 8'h03);
		wb(8'h14, 1'b1, 8'h01);
		wb(8'h0c, 1'b1, 8'h41);
		wb(8'h08, 1'b1, 8'h14);
		pulse_ack();
		chk({4'h0, irq_o}, 8'h02);
		wb(8'h14, 1'b1, 8'h00);
		wb(8'h10, 1'b0, 8'h00);
		chk(q, 8'h01);
		chk({4'h0, irq_o}, 8'h00);
		wb(8'h10, 1'b1, 8'h01);
		wb(8'h08, 1'b1, 8'h04);
		pulse_ack();
		wb(8'h10, 1'b0, 8'h00);
		chk(q, 8'h00);
		wb(8'h0c, 1'b1, 8'h00);
		wb(8'h08, 1'b0, 8'h00);
		chk(q, 8'h04);
		chk({6'h00, parallel_data_pins_oe, error_pin_oe}, 8'h02);
		wb(8'h04, 1'b0, 8'h00);
		chk(q, 8'h00);
		wb(8'h3c, 1'b0, 8'h00);
		chk(q, 8'h00);
		report_and_stop();
	end
endmodule

// ==== verification/psp_scanner_model.sv ====
// far-side scanner model: drives data toward the host and takes strobed bytes
`timescale 1ns/10ps
module psp_scanner_model (
	input wire logic mclk,
	input wire logic dir_i,
	input wire logic bufen_i,
	input wire logic strobe_i,
	input wire logic [7:0] host_data_i,
	input wire logic [7:0] scan_data_i,
	output logic [7:0] pins_o,
	output logic [7:0] rx_q
);
	logic [7:0] last_q;
	always_ff @(posedge mclk) begin
		if (!dir_i && !bufen_i) last_q <= scan_data_i;
		if (strobe_i) rx_q <= host_data_i;
	end
	// a released bus shows the inverse of its last value, never a stale copy
	assign pins_o = (dir_i || bufen_i) ? ~last_q : scan_data_i;
endmodule
